// [riw_pkg.sv]
package riw_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned RIW_CLOCK_MHZ        = 250;
  localparam int unsigned RIW_DRIVE_CYCLES     = 4;
  localparam int unsigned RIW_SAMPLE_DELAY     = 2;
  localparam int unsigned RIW_RATE_WINDOW      = 64;
  localparam int unsigned RIW_WDOG_BASE_LOG2   = 15;
  localparam int unsigned RIW_WDOG_WIDTH       = 28;

  // ----------------------------------------------------------------
  // Vector table
  // ----------------------------------------------------------------
  localparam logic [15:0] RIW_VEC_RESERVED_LO  = 16'hFFC0;
  localparam logic [15:0] RIW_VEC_RESERVED_HI  = 16'hFFD5;
  localparam logic [15:0] RIW_VEC_SERIAL       = 16'hFFD6;
  localparam logic [15:0] RIW_VEC_PERIPH_BASE  = 16'hFFD8;
  localparam logic [15:0] RIW_VEC_MASKPIN      = 16'hFFF2;
  localparam logic [15:0] RIW_VEC_NONMASK      = 16'hFFF4;
  localparam logic [15:0] RIW_VEC_TRAP         = 16'hFFF6;
  localparam logic [15:0] RIW_VEC_ILLEGAL      = 16'hFFF8;
  localparam logic [15:0] RIW_VEC_WATCHDOG     = 16'hFFFA;
  localparam logic [15:0] RIW_VEC_CLKMON       = 16'hFFFC;
  localparam logic [15:0] RIW_VEC_RESET        = 16'hFFFE;

  localparam int unsigned RIW_NUM_PERIPH       = 13;
  localparam int unsigned RIW_NUM_SERIAL       = 5;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [1:0]  RIW_RATE_RESET       = 2'h0;

  typedef enum logic [1:0] {
    RIW_RS_IDLE   = 2'b00,
    RIW_RS_DRIVE  = 2'b01,
    RIW_RS_WAIT   = 2'b11
  } riw_rst_state_t;

  typedef enum logic [2:0] {
    RIW_EX_RUN    = 3'b000,
    RIW_EX_FINISH = 3'b001,
    RIW_EX_STACK  = 3'b011,
    RIW_EX_MASK   = 3'b010,
    RIW_EX_FETCH  = 3'b110
  } riw_exc_state_t;

  typedef struct packed {
    logic        valid;
    logic [15:0] vector;
    logic        set_nonmask;
  } riw_service_t;

endpackage : riw_pkg

// [riw_reset_sense.sv]
`timescale 1ns/1ps
`default_nettype none
module riw_reset_sense
  import riw_pkg::*;
(
  input  wire logic clk,          // Bus clock
  input  wire logic rst,          // Synchronous reset
  input  wire logic trigger,      // Any reset condition sensed
  input  wire logic pin_in,       // Reset pin level
  output logic      pin_oe,       // Drive pin low while high
  output logic      done,         // Classification pulse
  output logic      external      // Classified as external
);

  riw_rst_state_t state;
  logic [2:0]     count;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state    <= RIW_RS_IDLE;
      count    <= 3'h0;
      pin_oe   <= 1'b0;
      done     <= 1'b0;
      external <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      unique case (state)
        RIW_RS_IDLE:
        begin
          if (trigger)
          begin
            state  <= RIW_RS_DRIVE;
            pin_oe <= 1'b1;                                     // RL2
            count  <= 3'(RIW_DRIVE_CYCLES - 1);
          end
        end
        RIW_RS_DRIVE:
        begin
          if (count == 3'h0)
          begin
            state  <= RIW_RS_WAIT;
            pin_oe <= 1'b0;                                     // RL2
            count  <= 3'(RIW_SAMPLE_DELAY - 1);
          end
          else
            count <= count - 3'h1;
        end
        RIW_RS_WAIT:
        begin
          if (count == 3'h0)
          begin
            state    <= RIW_RS_IDLE;
            done     <= 1'b1;
            external <= ~pin_in;                                // RL1 RL3 RL4
          end
          else
            count <= count - 3'h1;
        end
        default:
          state <= RIW_RS_IDLE;
      endcase
    end
  end

  drive_len_a: assert property (@(posedge clk) disable iff (rst)
    $rose(pin_oe) |-> pin_oe [*4] ##1 !pin_oe)                  // RL2
    else $error("Reset pin not driven for four cycles");
  sample_time_a: assert property (@(posedge clk) disable iff (rst)
    $fell(pin_oe) |-> ##1 !done ##1 done)                       // RL3
    else $error("Reset pin not sampled two cycles after release");

endmodule : riw_reset_sense
`default_nettype wire

// [riw_vector_sel.sv]
`timescale 1ns/1ps
`default_nettype none
module riw_vector_sel
  import riw_pkg::*;
#(
  parameter int unsigned NP = RIW_NUM_PERIPH
)(
  input  wire logic          nonmask_req,   // Nonmaskable request pending
  input  wire logic          mask_req,      // Maskable pin request
  input  wire logic          serial_req,    // Shared serial request
  input  wire logic [NP-1:0] periph_req,    // Peripherals, bit 0 highest
  input  wire logic          global_mask,   // Global mask flag
  input  wire logic          nonmask_mask,  // Nonmaskable mask flag
  output riw_service_t       service        // Winning request
);

  // Lowest vector address among peripherals has highest priority
  always_comb
  begin
    service = '{valid: 1'b0, vector: RIW_VEC_RESET, set_nonmask: 1'b0};
    if (!global_mask)                                           // RL13
    begin
      if (serial_req)
        service = '{valid: 1'b1, vector: RIW_VEC_SERIAL, set_nonmask: 1'b0};  // RL12
      for (int i = NP - 1; i >= 0; i--)
        if (periph_req[i])
          service = '{valid: 1'b1, set_nonmask: 1'b0,
                      vector: 16'(RIW_VEC_MASKPIN - 16'(2 * (NP - i)))};
      if (mask_req)
        service = '{valid: 1'b1, vector: RIW_VEC_MASKPIN, set_nonmask: 1'b0};
    end
    if (nonmask_req && !nonmask_mask)
      service = '{valid: 1'b1, vector: RIW_VEC_NONMASK, set_nonmask: 1'b1};  // RL16
  end

endmodule : riw_vector_sel
`default_nettype wire

// [riw_top.sv]
// Function
// [RL1] Classify reset by pin rise after release
// [RL2] Drive reset pin low four cycles
// [RL3] Sample pin two cycles later; low external
// [RL4] High sample means watchdog or clock fail
// [RL5] Unserviced enabled watchdog causes system reset
// [RL6] Watchdog enable latched only at reset
// [RL7] Test modes inhibit watchdog until bit cleared
// [RL8] Timeout bus clock over 2^15 times rate
// [RL9] Reset clears rate select to shortest
// [RL10] Rate written once in first 64 cycles; code lets special mode write it any time
// [RL11] Fixed two-byte vectors, reset at FFFE
// [RL12] Serial sources share one gated vector
// [RL13] Request needs local enable and global mask
// [RL14] Finish current instruction before servicing
// [RL15] Set masks after flags pushed
// [RL16] Fetch highest-priority vector and jump
// [RL17] Trap ignores masks and sets global mask
// [RL18] Maskable pin level-sensitive active-low
// [RL19] Event flag requests until software clears
// [RL20] Disable bit one disables watchdog
// [RL21] Push registers then flags before vector
`timescale 1ns/1ps
`default_nettype none
module riw_top
  import riw_pkg::*;
#(
  parameter int unsigned NP          = RIW_NUM_PERIPH,
  parameter int unsigned WDOG_BASE   = RIW_WDOG_BASE_LOG2,
  parameter int unsigned STACK_BEATS = 9
)(
  input  wire logic          CLOCK,           // Bus clock
  input  wire logic          RST,             // Synchronous reset
  input  wire logic          RESET_PIN_IN,    // Reset pin level
  output logic               RESET_PIN_OUT,   // Reset pin drive value
  output logic               RESET_PIN_OE,    // Reset pin drive enable
  input  wire logic          CLKMON_FAIL,     // Clock monitor failure
  input  wire logic          SPECIAL_MODE,    // Test or bootstrap mode
  input  wire logic          WATCHDOG_DISABLE_BIT, // Config disable bit
  input  wire logic          DISABLE_RESETS_WR,   // Write strobe
  input  wire logic          DISABLE_RESETS_DATA, // Write data
  input  wire logic          RATE_WR,         // Rate select write strobe
  input  wire logic [1:0]    RATE_DATA,       // Rate select write data
  input  wire logic          WATCHDOG_SERVICE,// Software service pulse
  input  wire logic          NONMASK_PIN_N,   // Nonmaskable request pin
  input  wire logic          MASK_PIN_N,      // Maskable request pin
  input  wire logic [4:0]    SERIAL_EVENT,    // Serial event pulses
  input  wire logic [4:0]    SERIAL_EN,       // Serial local enables
  input  wire logic [4:0]    SERIAL_CLR,      // Serial flag clears
  input  wire logic [NP-1:0] PERIPH_REQ,      // Enabled peripheral requests
  input  wire logic          INSN_DONE,       // Instruction boundary
  input  wire logic          TRAP_EXEC,       // Trap instruction executes
  input  wire logic          GMASK_CLR,       // Software clears global mask
  input  wire logic          GMASK_SET,       // Software sets global mask
  input  wire logic          STACK_ACK,       // Core pushed one byte
  output logic               SYS_RESET,       // System reset to core
  output logic               RESET_EXTERNAL,  // Last reset was external
  output logic               RESET_CLASS_VALID, // Classification done
  output logic               WATCHDOG_ENABLED,// Watchdog armed state
  output logic [1:0]         RATE_SEL,        // Watchdog rate select
  output logic               DISABLE_RESETS,  // Watchdog resets inhibited
  output logic [4:0]         SERIAL_FLAGS,    // Serial event flags
  output logic               GLOBAL_MASK,     // Global mask flag
  output logic               NONMASK_MASK,    // Nonmaskable mask flag
  output logic               STACK_REQ,       // Core should push registers
  output logic               VECTOR_VALID,    // Vector fetch pulse
  output logic [15:0]        VECTOR_ADDR      // Vector address
);

  // ----------------------------------------------------------------
  // Reset pin sensing
  // ----------------------------------------------------------------
  logic wdog_fire;
  logic sense_oe;
  logic sense_done;
  logic sense_ext;
  logic sense_busy;
  logic rst_d;

  // Pin sequence starts once the reset input has been released
  always_ff @(posedge CLOCK)
  begin
    rst_d <= RST;
  end

  riw_reset_sense u_sense (
    .clk      (CLOCK),
    .rst      (RST),
    .trigger  ((rst_d & ~RST) | wdog_fire | CLKMON_FAIL),
    .pin_in   (RESET_PIN_IN),
    .pin_oe   (sense_oe),
    .done     (sense_done),
    .external (sense_ext)
  );

  always_ff @(posedge CLOCK)
  begin
    RESET_PIN_OUT <= 1'b0;
    RESET_PIN_OE  <= sense_oe;                                  // RL2
  end

  always_ff @(posedge CLOCK)
  begin
    if (RST)
    begin
      sense_busy        <= 1'b1;
      RESET_EXTERNAL    <= 1'b0;
      RESET_CLASS_VALID <= 1'b0;
    end
    else if (wdog_fire || CLKMON_FAIL)
    begin
      sense_busy        <= 1'b1;
      RESET_CLASS_VALID <= 1'b0;
    end
    else if (sense_done)
    begin
      sense_busy        <= 1'b0;
      RESET_EXTERNAL    <= sense_ext;                           // RL3 RL4
      RESET_CLASS_VALID <= 1'b1;
    end
  end

  // System reset held until pin classification completes
  logic sys_rst;
  assign sys_rst = RST | sense_busy;

  always_ff @(posedge CLOCK)
  begin
    SYS_RESET <= RST | sense_busy | wdog_fire | CLKMON_FAIL;    // RL5
  end

  // ----------------------------------------------------------------
  // Watchdog configuration
  // ----------------------------------------------------------------
  logic [6:0] since_reset;
  logic       rate_written;

  always_ff @(posedge CLOCK)
  begin
    if (sys_rst)
      WATCHDOG_ENABLED <= ~WATCHDOG_DISABLE_BIT;                // RL6 RL20
  end

  always_ff @(posedge CLOCK)
  begin
    if (sys_rst)
      DISABLE_RESETS <= SPECIAL_MODE;                           // RL7
    else if (DISABLE_RESETS_WR && SPECIAL_MODE)
      DISABLE_RESETS <= DISABLE_RESETS_DATA;                    // RL7
  end

  always_ff @(posedge CLOCK)
  begin
    if (sys_rst)
      since_reset <= 7'h00;
    else if (since_reset != 7'(RIW_RATE_WINDOW))
      since_reset <= since_reset + 7'h01;
  end

  always_ff @(posedge CLOCK)
  begin
    if (sys_rst)
    begin
      RATE_SEL     <= RIW_RATE_RESET;                           // RL9
      rate_written <= 1'b0;
    end
    else if (RATE_WR && (SPECIAL_MODE ||
             (!rate_written && since_reset < 7'(RIW_RATE_WINDOW))))
    begin
      RATE_SEL     <= RATE_DATA;                                // RL10
      rate_written <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Watchdog timer
  // ----------------------------------------------------------------
  logic [RIW_WDOG_WIDTH-1:0] wdog_count;
  logic [RIW_WDOG_WIDTH-1:0] wdog_limit;

  assign wdog_limit = RIW_WDOG_WIDTH'(1) << (WDOG_BASE + 2 * RATE_SEL);  // RL8

  always_ff @(posedge CLOCK)
  begin
    if (sys_rst || WATCHDOG_SERVICE || !WATCHDOG_ENABLED)
      wdog_count <= '0;
    else
      wdog_count <= wdog_count + RIW_WDOG_WIDTH'(1);
  end

  assign wdog_fire = !sys_rst && WATCHDOG_ENABLED && !DISABLE_RESETS
                     && !WATCHDOG_SERVICE
                     && (wdog_count == wdog_limit - RIW_WDOG_WIDTH'(1));  // RL5

  // ----------------------------------------------------------------
  // Request flags
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < RIW_NUM_SERIAL; g++)
    begin : g_serial
      always_ff @(posedge CLOCK)
      begin
        if (sys_rst)
          SERIAL_FLAGS[g] <= 1'b0;
        else if (SERIAL_EVENT[g])
          SERIAL_FLAGS[g] <= 1'b1;                              // RL19
        else if (SERIAL_CLR[g])
          SERIAL_FLAGS[g] <= 1'b0;                              // RL19
      end
    end
  endgenerate

  logic serial_req;
  assign serial_req = |(SERIAL_FLAGS & SERIAL_EN);              // RL12 RL13

  // ----------------------------------------------------------------
  // Exception sequencer
  // ----------------------------------------------------------------
  riw_service_t   svc;
  riw_service_t   held;
  riw_exc_state_t state;
  logic [3:0]     beats;
  logic           is_trap;

  riw_vector_sel #(.NP(NP)) u_sel (
    .nonmask_req  (~NONMASK_PIN_N),
    .mask_req     (~MASK_PIN_N),                                // RL18
    .serial_req   (serial_req),
    .periph_req   (PERIPH_REQ),
    .global_mask  (GLOBAL_MASK),
    .nonmask_mask (NONMASK_MASK),
    .service      (svc)
  );

  always_ff @(posedge CLOCK)
  begin
    if (sys_rst)
    begin
      state        <= RIW_EX_FETCH;
      held         <= '{valid: 1'b1, vector: RIW_VEC_RESET, set_nonmask: 1'b0};  // RL11
      beats        <= 4'h0;
      is_trap      <= 1'b0;
      STACK_REQ    <= 1'b0;
      VECTOR_VALID <= 1'b0;
      VECTOR_ADDR  <= RIW_VEC_RESET;
    end
    else
    begin
      VECTOR_VALID <= 1'b0;
      unique case (state)
        RIW_EX_RUN:
        begin
          if (TRAP_EXEC)
          begin
            held    <= '{valid: 1'b1, vector: RIW_VEC_TRAP, set_nonmask: 1'b0};  // RL17
            is_trap <= 1'b1;
            state   <= RIW_EX_STACK;
            STACK_REQ <= 1'b1;
            beats   <= 4'(STACK_BEATS);
          end
          else if (svc.valid)
            state <= RIW_EX_FINISH;                             // RL14
        end
        RIW_EX_FINISH:
        begin
          if (INSN_DONE)
          begin
            if (svc.valid)
            begin
              held      <= svc;                                 // RL16
              is_trap   <= 1'b0;
              state     <= RIW_EX_STACK;
              STACK_REQ <= 1'b1;                                // RL21
              beats     <= 4'(STACK_BEATS);
            end
            else
              state <= RIW_EX_RUN;
          end
        end
        RIW_EX_STACK:
        begin
          if (STACK_ACK)
          begin
            if (beats == 4'h1)
            begin
              STACK_REQ <= 1'b0;
              state     <= RIW_EX_MASK;                         // RL15
            end
            beats <= beats - 4'h1;
          end
        end
        RIW_EX_MASK:
          state <= RIW_EX_FETCH;
        RIW_EX_FETCH:
        begin
          VECTOR_VALID <= 1'b1;
          VECTOR_ADDR  <= held.vector;                          // RL16
          state        <= RIW_EX_RUN;
        end
        default:
          state <= RIW_EX_RUN;
      endcase
    end
  end

  // Mask flags; set after flags have been pushed
  always_ff @(posedge CLOCK)
  begin
    if (sys_rst)
    begin
      GLOBAL_MASK  <= 1'b1;
      NONMASK_MASK <= 1'b1;
    end
    else if (state == RIW_EX_MASK)
    begin
      GLOBAL_MASK <= 1'b1;                                      // RL15 RL17
      if (held.set_nonmask)
        NONMASK_MASK <= 1'b1;                                   // RL15
    end
    else
    begin
      if (GMASK_SET)
        GLOBAL_MASK <= 1'b1;
      else if (GMASK_CLR)
        GLOBAL_MASK <= 1'b0;
      if (INSN_DONE && NONMASK_MASK && !is_trap)
        NONMASK_MASK <= NONMASK_MASK;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  rate_lock_a: assert property (@(posedge CLOCK) disable iff (sys_rst)
    (!SPECIAL_MODE && rate_written) |=> $stable(RATE_SEL))      // RL10
    else $error("Rate select changed after lock");
  rate_reset_a: assert property (@(posedge CLOCK)
    RST |=> RATE_SEL == 2'h0)                                   // RL9
    else $error("Rate select not cleared by reset");
  wdog_cfg_a: assert property (@(posedge CLOCK) disable iff (sys_rst)
    1'b1 |=> $stable(WATCHDOG_ENABLED))                         // RL6
    else $error("Watchdog enable changed outside reset");
  wdog_fire_a: assert property (@(posedge CLOCK) disable iff (RST)
    wdog_fire |=> SYS_RESET)                                    // RL5
    else $error("Watchdog expiry gave no reset");
  inhibit_a: assert property (@(posedge CLOCK) disable iff (sys_rst)
    DISABLE_RESETS |-> !wdog_fire)                              // RL7
    else $error("Inhibited watchdog fired");
  flag_hold_a: assert property (@(posedge CLOCK) disable iff (sys_rst)
    SERIAL_EVENT[0] |=> SERIAL_FLAGS[0])                        // RL19
    else $error("Serial event lost");
  mask_after_a: assert property (@(posedge CLOCK) disable iff (sys_rst)
    (state == RIW_EX_MASK) |=> GLOBAL_MASK && VECTOR_VALID == 1'b0 ##1 VECTOR_VALID)  // RL15
    else $error("Mask not set before vector fetch");
  boundary_a: assert property (@(posedge CLOCK) disable iff (sys_rst)
    (state == RIW_EX_FINISH && !INSN_DONE) |=> !STACK_REQ)      // RL14
    else $error("Stacking before instruction end");
  trap_vec_a: assert property (@(posedge CLOCK) disable iff (sys_rst)
    (state == RIW_EX_RUN && TRAP_EXEC) |=> held.vector == RIW_VEC_TRAP)  // RL17
    else $error("Trap vector wrong");

  trap_c: cover property (@(posedge CLOCK) VECTOR_VALID && VECTOR_ADDR == RIW_VEC_TRAP);
  nmi_c: cover property (@(posedge CLOCK) VECTOR_VALID && VECTOR_ADDR == RIW_VEC_NONMASK);
  ext_c: cover property (@(posedge CLOCK) RESET_CLASS_VALID && RESET_EXTERNAL);
  wdog_c: cover property (@(posedge CLOCK) wdog_fire);

endmodule : riw_top
`default_nettype wire

// [riw_core_model.sv]
`timescale 1ns/1ps
`default_nettype none
module riw_core_model
  import riw_pkg::*;
(
  input  wire logic   clk,       // Bus clock
  input  wire logic   rst,       // Sync reset
  input  wire logic   stack_req, // Push request
  input  wire logic   pin_oe,    // Reset pin drive
  input  wire logic   ext_hold,  // External reset hold
  input  wire logic   slow,      // Slow acks
  output logic        stack_ack, // One byte pushed
  output logic        pin_level, // Pulled-up pin
  output logic [15:0] ack_total  // Bytes pushed
);
  logic [1:0] gap;
  // Open-drain line with pull-up
  assign pin_level = ~(pin_oe | ext_hold);
  // Never two acks in a row, so no byte beyond the request
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      stack_ack <= 1'b0;
      gap       <= 2'h0;
    end
    else
    begin
      gap       <= gap + 2'h1;
      stack_ack <= stack_req & ~stack_ack & (~slow | (gap == 2'h3));
    end
  end
  always_ff @(posedge clk)
  begin
    if (rst)
      ack_total <= 16'h0;
    else if (stack_ack)
      ack_total <= ack_total + 16'h1;
  end
endmodule : riw_core_model
`default_nettype wire

// [tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import riw_pkg::*;
  logic        CLOCK, RST, RESET_PIN_IN, RESET_PIN_OUT, RESET_PIN_OE, CLKMON_FAIL, SPECIAL_MODE;
  logic        WATCHDOG_DISABLE_BIT, DISABLE_RESETS_WR, DISABLE_RESETS_DATA, RATE_WR, WATCHDOG_SERVICE;
  logic        NONMASK_PIN_N, MASK_PIN_N, INSN_DONE, TRAP_EXEC, GMASK_CLR, GMASK_SET, STACK_ACK;
  logic        SYS_RESET, RESET_EXTERNAL, RESET_CLASS_VALID, WATCHDOG_ENABLED, DISABLE_RESETS;
  logic        GLOBAL_MASK, NONMASK_MASK, STACK_REQ, VECTOR_VALID, ext_hold, slow;
  logic [1:0]  RATE_DATA, RATE_SEL;
  logic [4:0]  SERIAL_EVENT, SERIAL_EN, SERIAL_CLR, SERIAL_FLAGS;
  logic [12:0] PERIPH_REQ;
  logic [15:0] VECTOR_ADDR, acks;
  int          err_total, tests_run, oe_n;
  int          cyc = 0;

  riw_top #(.WDOG_BASE(4)) riw_top_inst (.CLOCK(CLOCK), .RST(RST), .RESET_PIN_IN(RESET_PIN_IN),
    .RESET_PIN_OUT(RESET_PIN_OUT), .RESET_PIN_OE(RESET_PIN_OE), .CLKMON_FAIL(CLKMON_FAIL),
    .SPECIAL_MODE(SPECIAL_MODE), .WATCHDOG_DISABLE_BIT(WATCHDOG_DISABLE_BIT),
    .DISABLE_RESETS_WR(DISABLE_RESETS_WR), .DISABLE_RESETS_DATA(DISABLE_RESETS_DATA),
    .RATE_WR(RATE_WR), .RATE_DATA(RATE_DATA), .WATCHDOG_SERVICE(WATCHDOG_SERVICE),
    .NONMASK_PIN_N(NONMASK_PIN_N), .MASK_PIN_N(MASK_PIN_N), .SERIAL_EVENT(SERIAL_EVENT),
    .SERIAL_EN(SERIAL_EN), .SERIAL_CLR(SERIAL_CLR), .PERIPH_REQ(PERIPH_REQ), .INSN_DONE(INSN_DONE),
    .TRAP_EXEC(TRAP_EXEC), .GMASK_CLR(GMASK_CLR), .GMASK_SET(GMASK_SET), .STACK_ACK(STACK_ACK),
    .SYS_RESET(SYS_RESET), .RESET_EXTERNAL(RESET_EXTERNAL), .RESET_CLASS_VALID(RESET_CLASS_VALID),
    .WATCHDOG_ENABLED(WATCHDOG_ENABLED), .RATE_SEL(RATE_SEL), .DISABLE_RESETS(DISABLE_RESETS),
    .SERIAL_FLAGS(SERIAL_FLAGS), .GLOBAL_MASK(GLOBAL_MASK), .NONMASK_MASK(NONMASK_MASK),
    .STACK_REQ(STACK_REQ), .VECTOR_VALID(VECTOR_VALID), .VECTOR_ADDR(VECTOR_ADDR));

  riw_core_model riw_core_model_inst (.clk(CLOCK), .rst(RST), .stack_req(STACK_REQ),
    .pin_oe(RESET_PIN_OE), .ext_hold(ext_hold), .slow(slow), .stack_ack(STACK_ACK),
    .pin_level(RESET_PIN_IN), .ack_total(acks));

  // ----
  // Tasks
  // ----
  task results;
    $display("Checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : results

  task chk(input string n, input logic [15:0] e, input logic [15:0] g);
    tests_run++;
    if (g !== e)
    begin
      err_total++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  // Bounded wait for the vector pulse, counting pin drive cycles
  task wait_vec;
    int i;
    oe_n = 0;
    for (i = 0; i < 100; i++)
    begin
      @(posedge CLOCK);
      #1;
      if (RESET_PIN_OE === 1'b1)
        oe_n++;
      if (VECTOR_VALID === 1'b1)
        break;
    end
    chk("vector pulse", 16'h1, {15'h0, VECTOR_VALID});
  endtask : wait_vec

  task do_reset(input logic ext);
    @(posedge CLOCK);
    #1;
    ext_hold = ext;
    RST = 1'b1;
    repeat (5) @(posedge CLOCK);
    #1;
    RST = 1'b0;
    wait_vec;
    chk("reset vector", RIW_VEC_RESET, VECTOR_ADDR);
    chk("drive cycles", 16'h4, 16'(oe_n));
    chk("external", {15'h0, ext}, {15'h0, RESET_EXTERNAL});
    chk("gmask reset", 16'h1, {15'h0, GLOBAL_MASK});
    chk("xmask reset", 16'h1, {15'h0, NONMASK_MASK});
    chk("class valid", 16'h1, {15'h0, RESET_CLASS_VALID});
    chk("pin out low", 16'h0, {15'h0, RESET_PIN_OUT});
    #1;
    ext_hold = 1'b0;
  endtask : do_reset

  task gclr;
    @(posedge CLOCK);
    #1;
    GMASK_CLR = 1'b1;
    @(posedge CLOCK);
    #1;
    GMASK_CLR = 1'b0;
  endtask : gclr

  task serve(input logic trap, input logic [15:0] v);
    logic [15:0] a0;
    repeat (2) @(posedge CLOCK);
    #1;
    a0 = acks;
    TRAP_EXEC = trap;
    INSN_DONE = ~trap;
    @(posedge CLOCK);
    #1;
    TRAP_EXEC = 1'b0;
    INSN_DONE = 1'b0;
    wait_vec;
    chk("vector", v, VECTOR_ADDR);
    @(posedge CLOCK);
    chk("gmask set", 16'h1, {15'h0, GLOBAL_MASK});
    chk("stack beats", 16'h9, acks - a0);
    #1;
  endtask : serve

  initial
  begin
    CLOCK = 1'b0;
    forever #2 CLOCK = ~CLOCK;
  end

  always @(posedge CLOCK)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      err_total++;
      results();
    end
  end

  // ----
  // Tests
  // ----
  initial
  begin
    {RST, WATCHDOG_DISABLE_BIT, MASK_PIN_N, NONMASK_PIN_N} = 4'hF;
    {CLKMON_FAIL, SPECIAL_MODE, DISABLE_RESETS_WR, DISABLE_RESETS_DATA, RATE_WR} = 5'h0;
    {WATCHDOG_SERVICE, INSN_DONE, TRAP_EXEC, GMASK_CLR, GMASK_SET, ext_hold, slow} = 7'h0;
    {SERIAL_EVENT, SERIAL_EN, SERIAL_CLR} = 15'h0;
    RATE_DATA = 2'h0;
    PERIPH_REQ = 13'h0;
    err_total = 0;
    tests_run = 0;
    do_reset(1'b0);
    chk("rate reset", 16'h0, {14'h0, RATE_SEL});
    chk("wdog off", 16'h0, {15'h0, WATCHDOG_ENABLED});
    RATE_WR = 1'b1;
    RATE_DATA = 2'h3;
    @(posedge CLOCK);
    #1;
    RATE_DATA = 2'h1;
    RATE_WR = 1'b0;
    @(posedge CLOCK);
    #1;
    RATE_WR = 1'b1;
    @(posedge CLOCK);
    #1;
    RATE_WR = 1'b0;
    WATCHDOG_DISABLE_BIT = 1'b0;
    repeat (3) @(posedge CLOCK);
    chk("rate once", 16'h3, {14'h0, RATE_SEL});
    chk("wdog latched", 16'h0, {15'h0, WATCHDOG_ENABLED});
    $display("test reset and config done");
    #1;
    MASK_PIN_N = 1'b0;
    INSN_DONE = 1'b1;
    @(posedge CLOCK);
    #1;
    INSN_DONE = 1'b0;
    repeat (10) @(posedge CLOCK);
    chk("masked wait", 16'h0, {15'h0, STACK_REQ});
    gclr;
    PERIPH_REQ[12] = 1'b1;
    serve(1'b0, RIW_VEC_MASKPIN);
    MASK_PIN_N = 1'b1;
    slow = 1'b1;
    gclr;
    serve(1'b0, 16'hFFF0);
    slow = 1'b0;
    PERIPH_REQ = 13'h0;
    $display("test priority done");
    SERIAL_EN = 5'h04;
    SERIAL_EVENT = 5'h05;
    @(posedge CLOCK);
    #1;
    SERIAL_EVENT = 5'h00;
    gclr;
    serve(1'b0, RIW_VEC_SERIAL);
    chk("flag holds", 16'h05, {11'h0, SERIAL_FLAGS});
    SERIAL_CLR = 5'h05;
    @(posedge CLOCK);
    #1;
    SERIAL_CLR = 5'h00;
    @(posedge CLOCK);
    chk("flag cleared", 16'h00, {11'h0, SERIAL_FLAGS});
    serve(1'b1, RIW_VEC_TRAP);
    $display("test serial and trap done");
    do_reset(1'b1);
    chk("wdog armed", 16'h1, {15'h0, WATCHDOG_ENABLED});
    for (int i = 0; i < 200 && SYS_RESET !== 1'b1; i++)
    begin
      @(posedge CLOCK);
      #1;
    end
    chk("wdog reset", 16'h1, {15'h0, SYS_RESET});
    wait_vec;
    chk("internal", 16'h0, {15'h0, RESET_EXTERNAL});
    chk("drive cycles", 16'h4, 16'(oe_n));
    $display("test watchdog done");
    #1;
    SPECIAL_MODE = 1'b1;
    WATCHDOG_DISABLE_BIT = 1'b1;
    do_reset(1'b0);
    chk("inhibit", 16'h1, {15'h0, DISABLE_RESETS});
    DISABLE_RESETS_WR = 1'b1;
    @(posedge CLOCK);
    #1;
    DISABLE_RESETS_WR = 1'b0;
    @(posedge CLOCK);
    chk("inhibit off", 16'h0, {15'h0, DISABLE_RESETS});
    $display("test special mode done");
    results();
  end
endmodule : tb_top
`default_nettype wire
